// *** hdl/pattern_pkg.sv ***
// package of register map, field positions, timing counts and state types for the test pattern block
package pattern_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register offsets and reset values
   localparam logic [7:0] REG_CTRL   = 8'h64;
   localparam logic [7:0] REG_CFG    = 8'h65;
   localparam logic [7:0] REG_IADDR  = 8'h66;
   localparam logic [7:0] REG_IDATA  = 8'h67;
   localparam logic [7:0] CTRL_RST   = 8'h10;
   localparam logic [7:0] CFG_RST    = 8'h00;
   localparam logic [7:0] IADDR_RST  = 8'h00;
   localparam logic [7:0] IND_RST    = 8'h00;
   localparam logic [7:0] CFG_MASK   = 8'h7F;

   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int CTRL_SEL_LSB = 4;
   localparam int CTRL_BARS    = 2;
   localparam int CTRL_REV     = 1;
   localparam int CTRL_EN      = 0;
   localparam int CFG_SCALE    = 6;
   localparam int CFG_CUST     = 5;
   localparam int CFG_18B      = 4;
   localparam int CFG_EXTCLK   = 3;
   localparam int CFG_TSEL     = 2;
   localparam int CFG_INV      = 1;
   localparam int CFG_AUTO     = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // indirect space
   localparam int         IND_DEPTH = 8;
   localparam logic [7:0] IND_FT    = 8'h00;
   localparam logic [7:0] IND_RED   = 8'h01;
   localparam logic [7:0] IND_GRN   = 8'h02;
   localparam logic [7:0] IND_BLU   = 8'h03;

   ////////////////////////////////////////////////////////////////////////////////
   // pattern codes and colour masks
   localparam logic [3:0]  PAT_CHECKER = 4'h0;
   localparam logic [3:0]  PAT_CUSTOM  = 4'hE;
   localparam logic [3:0]  PAT_COMMON_VOLTAGE_PATTERN    = 4'hF;
   localparam logic [23:0] MASK_18B    = 24'hFCFCFC;
   localparam logic [23:0] WHITE       = 24'hFFFFFF;

   ////////////////////////////////////////////////////////////////////////////////
   // internal timing counts
   localparam logic [1:0]  PIX_DIV  = 2'h3;
   localparam logic [10:0] H_ACTIVE = 11'h400;
   localparam logic [10:0] H_TOTAL  = 11'h44C;
   localparam logic [9:0]  V_ACTIVE = 10'h200;
   localparam logic [9:0]  V_TOTAL  = 10'h208;

   ////////////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic        de;
      logic        vs;
      logic [23:0] rgb;
   } video_t;

   typedef struct packed {
      logic [7:0]                 ctrl;
      logic [7:0]                 cfg;
      logic [7:0]                 iaddr;
      logic [IND_DEPTH-1:0][7:0]  ind;
      logic [7:0]                 rdata;
      logic [1:0]                 div;
      logic [2:0]                 pclk_sync;
      logic [2:0]                 de_sync;
      logic [2:0]                 vs_sync;
      logic [10:0]                h;
      logic [9:0]                 v;
      logic [7:0]                 frames;
      logic [3:0]                 cur_pat;
      video_t                     vid;
      logic                       strobe;
      logic                       active;
   } state_t;

endpackage

// *** hdl/pattern_gen.sv ***
// test pattern generator with configuration and indirect register access
`timescale 1ns/100ps

module pattern_gen
   import pattern_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RSTN,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [7:0]  REG_RDATA,
   input  wire logic        PCLK_EXT,
   input  wire logic        EXT_DE,
   input  wire logic        EXT_VS,
   output logic      [23:0] RGB_OUT,
   output logic             DE_OUT,
   output logic             VS_OUT,
   output logic             PIX_STROBE,
   output logic             PATTERN_ACTIVE
);

   ////////////////////////////////////////////////////////////////////////////////
   // colour of one pixel
   function automatic logic [23:0] pix_colour(
      input logic [3:0]  sel,
      input logic        bars,
      input logic        rev,
      input logic        scale,
      input logic        cust_chk,
      input logic [23:0] cust,
      input logic [10:0] h,
      input logic [9:0]  v
   );
      logic        chk;
      logic [7:0]  hl;
      logic [7:0]  vl;
      logic [1:0]  band;
      logic [23:0] bc;
      logic [23:0] c;
      chk  = scale ? (h[3] ^ v[3]) : (h[0] ^ v[0]);
      hl   = h[9:2];
      vl   = v[8:1];
      band = rev ? ~h[9:8] : h[9:8];
      case (band)
         2'h0:    bc = 24'hFFFF00;
         2'h1:    bc = 24'h00FFFF;
         2'h2:    bc = 24'h0000FF;
         default: bc = 24'hFF0000;
      endcase
      case (sel)
         PAT_CHECKER: c = chk ? (cust_chk ? cust : WHITE) : 24'h000000;
         4'h1:        c = WHITE;
         4'h2:        c = 24'h000000;
         4'h3:        c = 24'hFF0000;
         4'h4:        c = 24'h00FF00;
         4'h5:        c = 24'h0000FF;
         4'h6:        c = {hl, hl, hl};
         4'h7:        c = {hl, 8'h00, 8'h00};
         4'h8:        c = {8'h00, hl, 8'h00};
         4'h9:        c = {8'h00, 8'h00, hl};
         4'hA:        c = {vl, vl, vl};
         4'hB:        c = {vl, 8'h00, 8'h00};
         4'hC:        c = {8'h00, vl, 8'h00};
         4'hD:        c = {8'h00, 8'h00, vl};
         PAT_CUSTOM:  c = cust;
         PAT_COMMON_VOLTAGE_PATTERN:    c = chk ? bc : 24'h000000;
         default:     c = 24'h000000;
      endcase
      if (bars) begin
         c = {{8{~h[9]}}, {8{~h[8]}}, {8{~h[7]}}};
      end
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // state
   state_t      s_r;
   state_t      s_nxt;
   logic        ext_edge;
   logic        de_fall;
   logic        vs_rise;
   logic        div_tick;
   logic        step;
   logic        frame_done;
   logic        internal_tm;
   logic [7:0]  ft;
   logic [23:0] cust;
   logic [23:0] colour;
   logic        in_active;

   always_comb begin
      s_nxt = s_r;

      // pin synchronisers; stage 0 feeds stage 1 only
      s_nxt.pclk_sync = {s_r.pclk_sync[1:0], PCLK_EXT};
      s_nxt.de_sync   = {s_r.de_sync[1:0], EXT_DE};
      s_nxt.vs_sync   = {s_r.vs_sync[1:0], EXT_VS};
      ext_edge = s_r.pclk_sync[1] & ~s_r.pclk_sync[2];
      de_fall  = ~s_r.de_sync[1] & s_r.de_sync[2];
      vs_rise  = s_r.vs_sync[1] & ~s_r.vs_sync[2];

      ////////////////////////////////////////////////////////////////////////////
      // register port
      if (REG_WR) begin
         case (REG_ADDR)
            REG_CTRL:  s_nxt.ctrl  = REG_WDATA;
            REG_CFG:   s_nxt.cfg   = REG_WDATA & CFG_MASK;
            REG_IADDR: s_nxt.iaddr = REG_WDATA;
            REG_IDATA: begin
               if (s_r.iaddr < 8'(IND_DEPTH)) begin
                  s_nxt.ind[s_r.iaddr[2:0]] = REG_WDATA;
               end
            end
            default:   s_nxt.ctrl  = s_r.ctrl;
         endcase
      end
      if (REG_RD) begin
         case (REG_ADDR)
            REG_CTRL:  s_nxt.rdata = s_r.ctrl;
            REG_CFG:   s_nxt.rdata = s_r.cfg & CFG_MASK;
            REG_IADDR: s_nxt.rdata = s_r.iaddr;
            REG_IDATA: s_nxt.rdata = (s_r.iaddr < 8'(IND_DEPTH)) ? s_r.ind[s_r.iaddr[2:0]] : 8'h00;
            default:   s_nxt.rdata = 8'h00;
         endcase
      end

      ////////////////////////////////////////////////////////////////////////////
      // pixel clock choice
      internal_tm = s_r.cfg[CFG_TSEL];
      div_tick    = (s_r.div == PIX_DIV);
      s_nxt.div   = div_tick ? 2'h0 : s_r.div + 2'h1;
      if (internal_tm) begin
         step = s_r.cfg[CFG_EXTCLK] ? ext_edge : div_tick;
      end else begin
         step = ext_edge;
      end

      ////////////////////////////////////////////////////////////////////////////
      // timing counters
      frame_done = 1'b0;
      if (internal_tm) begin
         in_active = (s_r.h < H_ACTIVE) && (s_r.v < V_ACTIVE);
         if (step) begin
            if (s_r.h == H_TOTAL - 11'h001) begin
               s_nxt.h = 11'h000;
               if (s_r.v == V_TOTAL - 10'h001) begin
                  s_nxt.v    = 10'h000;
                  frame_done = 1'b1;
               end else begin
                  s_nxt.v = s_r.v + 10'h001;
               end
            end else begin
               s_nxt.h = s_r.h + 11'h001;
            end
         end
      end else begin
         in_active = s_r.de_sync[2];
         if (vs_rise) begin
            s_nxt.h    = 11'h000;
            s_nxt.v    = 10'h000;
            frame_done = 1'b1;
         end else if (de_fall) begin
            s_nxt.h = 11'h000;
            s_nxt.v = s_r.v + 10'h001;
         end else if (step && in_active) begin
            s_nxt.h = s_r.h + 11'h001;
         end
      end

      ////////////////////////////////////////////////////////////////////////////
      // pattern sequencing
      ft = s_r.ind[IND_FT[2:0]];
      if (!s_r.cfg[CFG_AUTO]) begin
         s_nxt.cur_pat = s_r.ctrl[CTRL_SEL_LSB +: 4];
         s_nxt.frames  = 8'h00;
      end else if (frame_done) begin
         if (s_r.frames + 8'h01 >= ft) begin
            s_nxt.cur_pat = s_r.cur_pat + 4'h1;
            s_nxt.frames  = 8'h00;
         end else begin
            s_nxt.frames = s_r.frames + 8'h01;
         end
      end

      ////////////////////////////////////////////////////////////////////////////
      // colour path
      cust   = {s_r.ind[IND_RED[2:0]], s_r.ind[IND_GRN[2:0]], s_r.ind[IND_BLU[2:0]]};
      colour = pix_colour(s_r.cur_pat, s_r.ctrl[CTRL_BARS], s_r.ctrl[CTRL_REV], s_r.cfg[CFG_SCALE],
                          s_r.cfg[CFG_CUST], cust, s_r.h, s_r.v);
      if (s_r.cfg[CFG_INV]) begin
         colour = ~colour;
      end
      if (s_r.cfg[CFG_18B]) begin
         colour = colour & MASK_18B;
      end

      s_nxt.active = s_r.ctrl[CTRL_EN];
      s_nxt.strobe = 1'b0;
      if (!s_r.ctrl[CTRL_EN]) begin
         s_nxt.vid = '0;
      end else if (step) begin
         s_nxt.strobe  = 1'b1;
         s_nxt.vid.de  = in_active;
         s_nxt.vid.vs  = internal_tm ? (s_r.v == V_TOTAL - 10'h001) : s_r.vs_sync[2];
         s_nxt.vid.rgb = in_active ? colour : 24'h000000;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         s_r       <= '0;
         s_r.ctrl  <= CTRL_RST;
         s_r.cfg   <= CFG_RST;
         s_r.iaddr <= IADDR_RST;
         s_r.ind   <= {IND_DEPTH{IND_RST}};
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign REG_RDATA      = s_r.rdata;
   assign RGB_OUT        = s_r.vid.rgb;
   assign DE_OUT         = s_r.vid.de;
   assign VS_OUT         = s_r.vid.vs;
   assign PIX_STROBE     = s_r.strobe;
   assign PATTERN_ACTIVE = s_r.active;

endmodule // pattern_gen

// *** verification/pattern_gen_assertions.sv ***
// concurrent checks on the ports of the test pattern block
`timescale 1ns/100ps
module pattern_gen_assertions
   import pattern_pkg::*;
(
   input wire logic        MCLK,
   input wire logic        RSTN,
   input wire logic [7:0]  REG_ADDR,
   input wire logic [7:0]  REG_WDATA,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [7:0]  REG_RDATA,
   input wire logic        PCLK_EXT,
   input wire logic [23:0] RGB_OUT,
   input wire logic        PIX_STROBE,
   input wire logic        PATTERN_ACTIVE
);
   logic [7:0] ia_r;
   logic [7:0] cfg_r;
   logic [3:0] low_r;
   logic       int_m;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);

   ////////////////////////////////////////////////////////////////////////////////
   // shadow of register contents and idle time of the external clock
   assign int_m = cfg_r[CFG_TSEL] & ~cfg_r[CFG_EXTCLK];
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         ia_r  <= 8'h00;
         cfg_r <= 8'h00;
         low_r <= 4'h0;
      end else begin
         if (REG_WR && REG_ADDR == REG_IADDR) ia_r <= REG_WDATA;
         if (REG_WR && REG_ADDR == REG_CFG) cfg_r <= REG_WDATA & CFG_MASK;
         low_r <= PCLK_EXT ? 4'h0 : ((low_r == 4'hF) ? low_r : low_r + 4'h1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   a_enable_copy: assert property (REG_WR && REG_ADDR == REG_CTRL |=> ##1
      PATTERN_ACTIVE == $past(REG_WDATA[CTRL_EN], 2)) else $error("enable flag wrong");
   a_iaddr_read: assert property (REG_RD && REG_ADDR == REG_IADDR |=>
      REG_RDATA == $past(ia_r)) else $error("indirect address readback wrong");
   a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
   a_off_quiet: assert property (!PATTERN_ACTIVE [*2] |-> !PIX_STROBE && RGB_OUT == 24'h0)
      else $error("output while disabled");
   a_internal_rate: assert property (PIX_STROBE && int_m |=> !PIX_STROBE [*3] ##1
      (PIX_STROBE || !PATTERN_ACTIVE || !int_m)) else $error("divided pixel rate wrong");
   a_ext_clock: assert property (!int_m && low_r == 4'hF |-> !PIX_STROBE)
      else $error("pixel step without external clock");
   a_rgb_hold: assert property (PATTERN_ACTIVE [*3] ##0 !PIX_STROBE |-> $stable(RGB_OUT))
      else $error("colour changed between pixels");
   a_mask_18b: assert property (PIX_STROBE && cfg_r[CFG_18B] |-> (RGB_OUT & ~MASK_18B) == 24'h0)
      else $error("low colour bits set in 18-bit mode");

   c_int_pix: cover property (PIX_STROBE && int_m);
   c_ext_pix: cover property (PIX_STROBE && !int_m);
   c_ind_read: cover property (REG_RD && REG_ADDR == REG_IDATA);
   c_auto_pix: cover property (PIX_STROBE && cfg_r[CFG_AUTO]);
endmodule // pattern_gen_assertions

bind pattern_gen pattern_gen_assertions u_chk (.MCLK(MCLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PCLK_EXT(PCLK_EXT),
   .RGB_OUT(RGB_OUT), .PIX_STROBE(PIX_STROBE), .PATTERN_ACTIVE(PATTERN_ACTIVE));

// *** verification/tb_pattern_gen.sv ***
// self-checking bench for the test pattern block
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb_pattern_gen
   import pattern_pkg::*;
;
   logic        MCLK = 1'b0;
   logic        RSTN = 1'b0;
   logic [7:0]  REG_ADDR = 8'h00;
   logic [7:0]  REG_WDATA = 8'h00;
   logic        REG_WR = 1'b0;
   logic        REG_RD = 1'b0;
   logic        PCLK_EXT = 1'b0;
   logic        EXT_DE = 1'b0;
   logic        EXT_VS = 1'b0;
   logic        ext_on = 1'b0;
   logic [2:0]  pc_cnt = 3'h0;
   logic [7:0]  REG_RDATA, rdat;
   logic [23:0] RGB_OUT, q0, cust;
   logic [23:0] p [16];
   logic        DE_OUT, VS_OUT, PIX_STROBE, PATTERN_ACTIVE;
   int          checks = 0;
   int          mismatches = 0;

   always #2.5 MCLK = ~MCLK;
   always @(negedge MCLK) begin
      pc_cnt <= pc_cnt + 3'h1;
      PCLK_EXT <= ext_on & pc_cnt[2];
   end

   pattern_gen DUT (.MCLK(MCLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
      .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PCLK_EXT(PCLK_EXT), .EXT_DE(EXT_DE), .EXT_VS(EXT_VS),
      .RGB_OUT(RGB_OUT), .DE_OUT(DE_OUT), .VS_OUT(VS_OUT), .PIX_STROBE(PIX_STROBE),
      .PATTERN_ACTIVE(PATTERN_ACTIVE));

   ////////////////////////////////////////////////////////////////////////////////
   // register access and pattern capture
   task acc(input bit w, input logic [7:0] a, input logic [7:0] wd);
      REG_ADDR = a;
      REG_WDATA = wd;
      REG_WR = w;
      REG_RD = !w;
      @(negedge MCLK);
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      rdat = REG_RDATA;
      @(negedge MCLK);
   endtask

   task rchk(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      `CHK(rdat, e)
   endtask

   task run(input logic [7:0] ctl, input logic [7:0] c, input logic [23:0] x, input bit s);
      int   i, n;
      logic de_prev;
      acc(1'b1, REG_CTRL, 8'h00);
      acc(1'b1, REG_CFG, c);
      acc(1'b1, REG_CTRL, ctl);
      // internal timing: capture starts at the first pixel of a line
      i = 0;
      n = 0;
      de_prev = 1'b1;
      while (i < 16 && n < 20000) begin
         @(posedge MCLK);
         #1;
         n++;
         if (PIX_STROBE) begin
            if (i > 0 || !c[CFG_TSEL] || (DE_OUT && !de_prev)) begin
               p[i] = RGB_OUT;
               i++;
            end
            de_prev = DE_OUT;
         end
      end
      `CHK(i, 16)
      for (i = 1; i < 16; i++) `CHK(p[i] ^ p[i-1], (s && i % 8 != 0) ? 24'h0 : x)
      @(negedge MCLK);
      acc(1'b1, REG_CTRL, 8'h00);
      repeat (3) @(negedge MCLK);
      `CHK(RGB_OUT, 24'h0)
   endtask

   task end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // test sequence
   initial begin
      #300000;
      mismatches++;
      end_of_test();
   end

   initial begin
      int i;
      repeat (20) @(negedge MCLK);
      RSTN = 1'b1;
      rchk(REG_CTRL, CTRL_RST);
      rchk(REG_CFG, CFG_RST);
      rchk(REG_IADDR, IADDR_RST);
      rchk(REG_IDATA, IND_RST);
      rchk(8'h68, 8'h00);
      acc(1'b1, REG_CFG, 8'hFF);
      rchk(REG_CFG, CFG_MASK);
      for (i = 0; i < 8; i++) begin
         acc(1'b1, REG_IADDR, i[7:0]);
         acc(1'b1, REG_IDATA, 8'h5A ^ i[7:0]);
      end
      for (i = 0; i < 8; i++) begin
         acc(1'b1, REG_IADDR, i[7:0]);
         rchk(REG_IADDR, i[7:0]);
         rchk(REG_IDATA, 8'h5A ^ i[7:0]);
      end
      acc(1'b1, REG_IADDR, 8'h08);
      acc(1'b1, REG_IDATA, 8'hEE);
      rchk(REG_IDATA, 8'h00);
      cust = {8'h5A ^ IND_RED, 8'h5A ^ IND_GRN, 8'h5A ^ IND_BLU};
      run(8'h01, 8'h04, WHITE, 1'b0);
      q0 = p[0];
      `CHK(q0 == WHITE || q0 == 24'h0, 1'b1)
      run(8'h21, 8'h06, 24'h0, 1'b0);
      `CHK(p[0], WHITE)
      run(8'h01, 8'h44, WHITE, 1'b1);
      run(8'h01, 8'h24, cust, 1'b0);
      run(8'h01, 8'h34, cust & MASK_18B, 1'b0);
      ext_on = 1'b1;
      EXT_DE = 1'b1;
      run(8'h01, 8'h0C, WHITE, 1'b0);
      run(8'h01, 8'h08, WHITE, 1'b0);
      run(8'h01, 8'h00, WHITE, 1'b0);
      acc(1'b1, REG_IADDR, IND_FT);
      acc(1'b1, REG_IDATA, 8'h01);
      run(8'h11, 8'h01, WHITE, 1'b0);
      EXT_VS = 1'b1;
      repeat (4) @(negedge MCLK);
      EXT_VS = 1'b0;
      repeat (4) @(negedge MCLK);
      run(8'h11, 8'h01, 24'h0, 1'b0);
      `CHK(p[0], WHITE)
      end_of_test();
   end
endmodule // tb_pattern_gen
